// ===== pmbcfg_bank.sv
`include "pmbcfg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Pin synchroniser
// ----------------------------------------
module pmbcfg_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin_in,
  output var logic [W-1:0] level_r
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  // Accept only once the later two stages agree
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      level_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule : pmbcfg_sync

// ----------------------------------------
// Command bank
// ----------------------------------------
module pmbcfg_bank (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [15:0] vout_strap,
  input wire logic [15:0] fsw_strap,
  input wire logic [6:0] bus_addr,
  input wire logic en_pin,
  input wire logic [7:0] cmd_code,
  input wire logic wr_req,
  input wire logic [15:0] wr_data,
  input wire logic snd_req,
  input wire logic rd_req,
  input wire logic [4:0] fault_evt,
  output logic ready,
  output logic [15:0] rd_data_r,
  output logic rd_valid_r,
  output logic cmd_err_r,
  output logic [4:0] fault_flags_r,
  output logic run_en_r,
  output logic [15:0] vout_target_r,
  output logic [15:0] slew_rate_r,
  output logic [15:0] fsw_r,
  output logic [15:0] phase_r,
  output logic user_saved_r
);
  pmbcfg_pkg::pmbcfg_state_t st_r;
  pmbcfg_pkg::pmbcfg_state_t st_nxt;
  pmbcfg_pkg::pmbcfg_word_t work_r [`PMBC_NREG];
  pmbcfg_pkg::pmbcfg_word_t user_r [`PMBC_NREG];
  pmbcfg_pkg::pmbcfg_word_t dflt [`PMBC_NREG];
  logic [2:0] wait_r;
  logic [15:0] vstrap_s;
  logic [15:0] fstrap_s;
  logic [6:0] addr_s;
  logic en_s;
  logic [15:0] strap_r;
  logic [15:0] fstrap_r;
  logic [6:0] addr_r;

  // Straps and enable arrive from pins
  pmbcfg_sync #(.W(16)) u_vsync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in(vout_strap),
    .level_r(vstrap_s)
  );
  pmbcfg_sync #(.W(16)) u_fsync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in(fsw_strap),
    .level_r(fstrap_s)
  );
  pmbcfg_sync #(.W(7)) u_async (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in(bus_addr),
    .level_r(addr_s)
  );
  pmbcfg_sync #(.W(1)) u_esync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in(en_pin),
    .level_r(en_s)
  );

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  function automatic logic [5:0] code_map(input logic [7:0] c);
    logic [5:0] m;
    m = 6'h00;
    unique case (c)
      `PMBC_CMD_RUN: m = {1'b1, `PMBC_IX_RUN};
      `PMBC_CMD_ONOFF: m = {1'b1, `PMBC_IX_ONOFF};
      `PMBC_CMD_VSET: m = {1'b1, `PMBC_IX_VSET};
      `PMBC_CMD_VTRIM: m = {1'b1, `PMBC_IX_VTRIM};
      `PMBC_CMD_VCEIL: m = {1'b1, `PMBC_IX_VCEIL};
      `PMBC_CMD_MHI: m = {1'b1, `PMBC_IX_MHI};
      `PMBC_CMD_MLO: m = {1'b1, `PMBC_IX_MLO};
      `PMBC_CMD_SLEW: m = {1'b1, `PMBC_IX_SLEW};
      `PMBC_CMD_LOADLN: m = {1'b1, `PMBC_IX_LOADLN};
      `PMBC_CMD_FSW: m = {1'b1, `PMBC_IX_FSW};
      `PMBC_CMD_PHASE: m = {1'b1, `PMBC_IX_PHASE};
      `PMBC_CMD_ISGAIN: m = {1'b1, `PMBC_IX_ISGAIN};
      `PMBC_CMD_ISTRIM: m = {1'b1, `PMBC_IX_ISTRIM};
      `PMBC_CMD_OVF: m = {1'b1, `PMBC_IX_OVF};
      `PMBC_CMD_OVR: m = {1'b1, `PMBC_IX_OVR};
      `PMBC_CMD_OVW: m = {1'b1, `PMBC_IX_OVW};
      `PMBC_CMD_UVW: m = {1'b1, `PMBC_IX_UVW};
      `PMBC_CMD_UVF: m = {1'b1, `PMBC_IX_UVF};
      `PMBC_CMD_UVR: m = {1'b1, `PMBC_IX_UVR};
      `PMBC_CMD_OCF: m = {1'b1, `PMBC_IX_OCF};
      `PMBC_CMD_UCF: m = {1'b1, `PMBC_IX_UCF};
      `PMBC_CMD_OTF: m = {1'b1, `PMBC_IX_OTF};
      default: m = 6'h00;
    endcase
    return m;
  endfunction : code_map

  wire [5:0] map_w = code_map(cmd_code);
  wire hit_w = map_w[5];
  wire [4:0] ix_w = map_w[4:0];
  wire is_byte_w = (ix_w == `PMBC_IX_RUN) || (ix_w == `PMBC_IX_ONOFF) ||
                   (ix_w == `PMBC_IX_OVR) || (ix_w == `PMBC_IX_UVR);
  wire is_fmt_w = (cmd_code == `PMBC_CMD_VFMT);
  wire running_w = (st_r == pmbcfg_pkg::PMBCFG_ST_RUN);
  wire do_wr_w = running_w && wr_req && hit_w;
  wire do_clr_w = running_w && snd_req && (cmd_code == `PMBC_CMD_CLRF);
  wire do_save_w = running_w && snd_req && (cmd_code == `PMBC_CMD_SAVE);
  wire do_load_w = running_w && snd_req && (cmd_code == `PMBC_CMD_RELOAD) && user_saved_r;
  wire snd_ok_w = (cmd_code == `PMBC_CMD_CLRF) || (cmd_code == `PMBC_CMD_SAVE) ||
                  (cmd_code == `PMBC_CMD_RELOAD);
  // Writes to the format code or unknown codes are refused
  wire bad_w = running_w && ((wr_req && !hit_w) || (rd_req && !hit_w && !is_fmt_w) ||
                             (snd_req && !snd_ok_w));
  wire [15:0] wr_val_w = is_byte_w ? (wr_data & `PMBC_BYTE_MASK) : wr_data;
  wire [15:0] rd_val_w = is_fmt_w ? `PMBC_RST_VFMT : (hit_w ? work_r[ix_w] : `PMBC_RST_ZERO);

  // ----------------------------------------
  // Strap-derived defaults
  // ----------------------------------------
  wire [15:0] tenth_w = strap_r / `PMBC_DIV_TENTH;
  wire [15:0] twent_w = strap_r / `PMBC_DIV_TWENTIETH;
  // Integer division by ten and by twenty; truncates toward zero
  always_comb begin
    for (int i = 0; i < `PMBC_NREG; i++) begin
      dflt[i] = `PMBC_RST_ZERO;
    end
    dflt[`PMBC_IX_RUN] = `PMBC_RST_RUN;
    dflt[`PMBC_IX_ONOFF] = `PMBC_RST_ONOFF;
    dflt[`PMBC_IX_VSET] = strap_r;
    dflt[`PMBC_IX_VTRIM] = `PMBC_RST_ZERO;
    dflt[`PMBC_IX_VCEIL] = 16'(strap_r + tenth_w);
    dflt[`PMBC_IX_MHI] = 16'(strap_r + twent_w);
    dflt[`PMBC_IX_MLO] = 16'(strap_r - twent_w);
    dflt[`PMBC_IX_SLEW] = `PMBC_RST_SLEW;
    dflt[`PMBC_IX_LOADLN] = `PMBC_RST_ZERO;
    dflt[`PMBC_IX_FSW] = fstrap_r;
    dflt[`PMBC_IX_PHASE] = {9'h000, addr_r} & `PMBC_PHASE_MASK;
    dflt[`PMBC_IX_ISGAIN] = `PMBC_RST_ISGAIN;
    dflt[`PMBC_IX_ISTRIM] = `PMBC_RST_ZERO;
    dflt[`PMBC_IX_OVF] = 16'(strap_r + tenth_w + twent_w);
    dflt[`PMBC_IX_OVR] = `PMBC_RST_REACT;
    dflt[`PMBC_IX_OVW] = 16'(strap_r + tenth_w);
    dflt[`PMBC_IX_UVW] = 16'(strap_r - tenth_w);
    dflt[`PMBC_IX_UVF] = 16'(strap_r - tenth_w - twent_w);
    dflt[`PMBC_IX_UVR] = `PMBC_RST_REACT;
    dflt[`PMBC_IX_OCF] = `PMBC_RST_OCF;
    dflt[`PMBC_IX_UCF] = `PMBC_RST_UCF;
    dflt[`PMBC_IX_OTF] = `PMBC_RST_OTF;
  end

  // ----------------------------------------
  // Start-up sequence
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      pmbcfg_pkg::PMBCFG_ST_INIT: begin
        if (wait_r == `PMBC_INIT_WAIT) begin
          st_nxt = pmbcfg_pkg::PMBCFG_ST_LOAD;
        end
      end
      pmbcfg_pkg::PMBCFG_ST_LOAD: st_nxt = pmbcfg_pkg::PMBCFG_ST_RUN;
      pmbcfg_pkg::PMBCFG_ST_RUN: st_nxt = st_r;
      default: st_nxt = pmbcfg_pkg::PMBCFG_ST_INIT;
    endcase
  end

  assign ready = running_w;

  // Straps are caught on every INIT cycle; the last catch comes after the synchronisers settle
  // Synchronisers need four edges, so the last capture must come after them
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= pmbcfg_pkg::PMBCFG_ST_INIT;
      wait_r <= 3'h0;
      strap_r <= `PMBC_RST_ZERO;
      fstrap_r <= `PMBC_RST_ZERO;
      addr_r <= 7'h00;
    end else begin
      st_r <= st_nxt;
      if (wait_r != `PMBC_INIT_WAIT) begin
        wait_r <= 3'(wait_r + 3'h1);
      end
      if (st_r == pmbcfg_pkg::PMBCFG_ST_INIT) begin
        strap_r <= vstrap_s;
        fstrap_r <= fstrap_s;
        addr_r <= addr_s;
      end
    end
  end

  // ----------------------------------------
  // Working and user storage
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      user_saved_r <= 1'b0;
      for (int i = 0; i < `PMBC_NREG; i++) begin
        work_r[i] <= `PMBC_RST_ZERO;
        user_r[i] <= `PMBC_RST_ZERO;
      end
    end else if (st_r == pmbcfg_pkg::PMBCFG_ST_LOAD) begin
      for (int i = 0; i < `PMBC_NREG; i++) begin
        work_r[i] <= dflt[i];
      end
    end else if (do_save_w) begin
      user_saved_r <= 1'b1;
      for (int i = 0; i < `PMBC_NREG; i++) begin
        user_r[i] <= work_r[i];
      end
    end else if (do_load_w) begin
      for (int i = 0; i < `PMBC_NREG; i++) begin
        work_r[i] <= user_r[i];
      end
    end else if (do_wr_w) begin
      work_r[ix_w] <= wr_val_w;
    end
  end

  // ----------------------------------------
  // Read answer and faults
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_data_r <= `PMBC_RST_ZERO;
    end else if (running_w && rd_req) begin
      rd_data_r <= rd_val_w;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= running_w && rd_req && (hit_w || is_fmt_w);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmd_err_r <= 1'b0;
    end else begin
      cmd_err_r <= bad_w;
    end
  end

  // New events win over a same-cycle clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fault_flags_r <= '0;
    end else begin
      fault_flags_r <= (fault_flags_r & ~{`PMBC_NFLT{do_clr_w}}) | fault_evt;
    end
  end

  // ----------------------------------------
  // Output steering
  // ----------------------------------------
  wire [15:0] op_w = work_r[`PMBC_IX_RUN];
  wire [15:0] oo_w = work_r[`PMBC_IX_ONOFF];
  wire pin_ok_w = (en_s == oo_w[`PMBC_OO_POL_BIT]);
  wire cmd_ok_w = !oo_w[`PMBC_OO_CMD_BIT] || op_w[`PMBC_OP_ON_BIT];
  wire hw_ok_w = !oo_w[`PMBC_OO_CPR_BIT] || pin_ok_w;
  wire ov_stop_w = fault_flags_r[`PMBC_FLT_OV] &&
                   (work_r[`PMBC_IX_OVR][`PMBC_REACT_HI:`PMBC_REACT_LO] != 2'h0);
  wire uv_stop_w = fault_flags_r[`PMBC_FLT_UV] &&
                   (work_r[`PMBC_IX_UVR][`PMBC_REACT_HI:`PMBC_REACT_LO] != 2'h0);
  wire run_nxt = running_w && (!oo_w[`PMBC_OO_PU_BIT] || (cmd_ok_w && hw_ok_w)) &&
                 !ov_stop_w && !uv_stop_w;
  // Margin high takes priority when both margin bits are set
  wire [15:0] vsel_w = op_w[`PMBC_OP_MHI_BIT] ? work_r[`PMBC_IX_MHI] :
                       (op_w[`PMBC_OP_MLO_BIT] ? work_r[`PMBC_IX_MLO] : work_r[`PMBC_IX_VSET]);
  wire signed [17:0] vsum_w = $signed({2'b00, vsel_w}) +
                              $signed({{2{work_r[`PMBC_IX_VTRIM][15]}}, work_r[`PMBC_IX_VTRIM]});
  wire [15:0] vclip_w = vsum_w[17] ? `PMBC_RST_ZERO : (vsum_w[16] ? 16'hFFFF : vsum_w[15:0]);
  wire [15:0] vout_nxt = (vclip_w > work_r[`PMBC_IX_VCEIL]) ? work_r[`PMBC_IX_VCEIL] : vclip_w;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      run_en_r <= 1'b0;
    end else begin
      run_en_r <= run_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      vout_target_r <= `PMBC_RST_ZERO;
    end else begin
      vout_target_r <= vout_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      slew_rate_r <= `PMBC_RST_ZERO;
    end else begin
      slew_rate_r <= work_r[`PMBC_IX_SLEW];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fsw_r <= `PMBC_RST_ZERO;
    end else begin
      fsw_r <= work_r[`PMBC_IX_FSW];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      phase_r <= `PMBC_RST_ZERO;
    end else begin
      phase_r <= work_r[`PMBC_IX_PHASE];
    end
  end
endmodule : pmbcfg_bank
`default_nettype wire

// ===== pmbcfg_consts.svh
`ifndef PMBCFG_CONSTS_SVH
`define PMBCFG_CONSTS_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define PMBC_CMD_RUN 8'h01
`define PMBC_CMD_ONOFF 8'h02
`define PMBC_CMD_CLRF 8'h03
`define PMBC_CMD_SAVE 8'h15
`define PMBC_CMD_RELOAD 8'h16
`define PMBC_CMD_VFMT 8'h20
`define PMBC_CMD_VSET 8'h21
`define PMBC_CMD_VTRIM 8'h23
`define PMBC_CMD_VCEIL 8'h24
`define PMBC_CMD_MHI 8'h25
`define PMBC_CMD_MLO 8'h26
`define PMBC_CMD_SLEW 8'h27
`define PMBC_CMD_LOADLN 8'h28
`define PMBC_CMD_FSW 8'h33
`define PMBC_CMD_PHASE 8'h37
`define PMBC_CMD_ISGAIN 8'h38
`define PMBC_CMD_ISTRIM 8'h39
`define PMBC_CMD_OVF 8'h40
`define PMBC_CMD_OVR 8'h41
`define PMBC_CMD_OVW 8'h42
`define PMBC_CMD_UVW 8'h43
`define PMBC_CMD_UVF 8'h44
`define PMBC_CMD_UVR 8'h45
`define PMBC_CMD_OCF 8'h46
`define PMBC_CMD_UCF 8'h4B
`define PMBC_CMD_OTF 8'h4F

// ----------------------------------------
// Storage indices
// ----------------------------------------
`define PMBC_NREG 22
`define PMBC_IX_RUN 5'h00
`define PMBC_IX_ONOFF 5'h01
`define PMBC_IX_VSET 5'h02
`define PMBC_IX_VTRIM 5'h03
`define PMBC_IX_VCEIL 5'h04
`define PMBC_IX_MHI 5'h05
`define PMBC_IX_MLO 5'h06
`define PMBC_IX_SLEW 5'h07
`define PMBC_IX_LOADLN 5'h08
`define PMBC_IX_FSW 5'h09
`define PMBC_IX_PHASE 5'h0A
`define PMBC_IX_ISGAIN 5'h0B
`define PMBC_IX_ISTRIM 5'h0C
`define PMBC_IX_OVF 5'h0D
`define PMBC_IX_OVR 5'h0E
`define PMBC_IX_OVW 5'h0F
`define PMBC_IX_UVW 5'h10
`define PMBC_IX_UVF 5'h11
`define PMBC_IX_UVR 5'h12
`define PMBC_IX_OCF 5'h13
`define PMBC_IX_UCF 5'h14
`define PMBC_IX_OTF 5'h15

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define PMBC_RST_RUN 16'h0000
`define PMBC_RST_ONOFF 16'h0017
`define PMBC_RST_VFMT 16'h0013
`define PMBC_RST_ZERO 16'h0000
`define PMBC_RST_SLEW 16'hBA00
`define PMBC_RST_ISGAIN 16'hB2AE
`define PMBC_RST_REACT 16'h0080
`define PMBC_RST_OCF 16'hE280
`define PMBC_RST_UCF 16'hE57F
`define PMBC_RST_OTF 16'hEBE8
`define PMBC_BYTE_MASK 16'h00FF
`define PMBC_DIV_TENTH 16'h000A
`define PMBC_DIV_TWENTIETH 16'h0014
`define PMBC_PHASE_MASK 16'h000F
`define PMBC_OP_ON_BIT 7
`define PMBC_OP_MHI_BIT 5
`define PMBC_OP_MLO_BIT 4
`define PMBC_OO_PU_BIT 4
`define PMBC_OO_CMD_BIT 3
`define PMBC_OO_CPR_BIT 2
`define PMBC_OO_POL_BIT 1
`define PMBC_NFLT 5
`define PMBC_FLT_OV 0
`define PMBC_FLT_UV 1
`define PMBC_REACT_HI 7
`define PMBC_REACT_LO 6
`define PMBC_INIT_WAIT 3'h4

`endif

// ===== pmbcfg_pkg.sv
`default_nettype none
package pmbcfg_pkg;
  typedef enum logic [2:0] {
    PMBCFG_ST_INIT = 3'h1,
    PMBCFG_ST_LOAD = 3'h2,
    PMBCFG_ST_RUN = 3'h4
  } pmbcfg_state_t;
  typedef logic [15:0] pmbcfg_word_t;
endpackage : pmbcfg_pkg
`default_nettype wire

// ===== pmbcfg_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pmbcfg_properties (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ready,
  input wire logic [7:0] cmd_code,
  input wire logic wr_req,
  input wire logic snd_req,
  input wire logic rd_req,
  input wire logic [4:0] fault_evt,
  input wire logic [15:0] rd_data_r,
  input wire logic rd_valid_r,
  input wire logic cmd_err_r,
  input wire logic [4:0] fault_flags_r,
  input wire logic user_saved_r
);
  // ----------------------------------------
  // Taken requests
  // ----------------------------------------
  wire logic t_rd = ready & rd_req;
  wire logic t_wr = ready & wr_req;
  wire logic t_sn = ready & snd_req;
  wire logic t_clr = t_sn & (cmd_code == 8'h03);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // One-cycle slack, the boot count edge is not pinned down
  sequence boot_s;
    !ready [*5] ##[1:2] ready;
  endsequence
  sequence answer_s;
    rd_valid_r != cmd_err_r;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  boot_ready_a: assert property ($fell(sys_rst) |-> boot_s)
    else $error("ready not up after reset");
  fmt_read_a: assert property (t_rd && cmd_code == 8'h20 |=> rd_valid_r && rd_data_r == 16'h0013)
    else $error("format code read wrong");
  fmt_write_a: assert property (t_wr && cmd_code == 8'h20 |=> cmd_err_r)
    else $error("format code write accepted");
  read_answer_a: assert property (t_rd |=> answer_s)
    else $error("read not answered once");
  idle_quiet_a: assert property (!(t_rd || t_wr || t_sn) |=> !rd_valid_r && !cmd_err_r)
    else $error("answer without request");
  send_err_a: assert property (t_sn && !(cmd_code inside {8'h03, 8'h15, 8'h16}) |=> cmd_err_r)
    else $error("unknown send accepted");
  save_mark_a: assert property (t_sn && cmd_code == 8'h15 |=> user_saved_r [*2])
    else $error("save not marked");
  clear_flags_a: assert property (t_clr |=> fault_flags_r == $past(fault_evt))
    else $error("clear left stale flags");
  flag_hold_a: assert property (!t_clr |=> (fault_flags_r & $past(fault_flags_r)) == $past(fault_flags_r))
    else $error("flag dropped without clear");
  flag_set_a: assert property (ready && fault_evt != 5'h00 |=> (fault_flags_r & $past(fault_evt)) == $past(fault_evt))
    else $error("fault event not latched");
endmodule : pmbcfg_properties
`default_nettype wire

// ===== pmbcfg_host.sv
`timescale 1ns/1ps
`default_nettype none
module pmbcfg_host (
  input wire logic mclk,
  input wire logic ready,
  output var logic [7:0] cmd_code,
  output var logic wr_req,
  output var logic [15:0] wr_data,
  output var logic snd_req,
  output var logic rd_req
);
  initial begin
    cmd_code = 8'h00;
    wr_req = 1'b0;
    wr_data = 16'h0000;
    snd_req = 1'b0;
    rd_req = 1'b0;
  end
  // Kind 1 write, 2 send, 3 read; held until an edge with ready
  task automatic xfer(input logic [1:0] kind, input logic [7:0] code, input logic [15:0] data);
    @(negedge mclk);
    cmd_code = code;
    wr_data = data;
    wr_req = (kind == 2'h1);
    snd_req = (kind == 2'h2);
    rd_req = (kind == 2'h3);
    // Ready is settled at the falling edge, so judge the taking edge there
    while (ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    @(negedge mclk);
    wr_req = 1'b0;
    snd_req = 1'b0;
    rd_req = 1'b0;
    // Stale code and data inverted so a leftover value cannot pass
    cmd_code = ~code;
    wr_data = ~data;
  endtask : xfer
endmodule : pmbcfg_host
`default_nettype wire

// ===== pmbcfg_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pmbcfg_bank_tb;
  // ----------------------------------------
  // Wiring
  // ----------------------------------------
  localparam logic [15:0] V = 16'h2000;
  localparam logic [15:0] F = 16'h0190;
  localparam logic [6:0] A = 7'h2B;
  localparam logic [15:0] VT = V / 16'h000A;
  localparam logic [15:0] VW = V / 16'h0014;
  logic mclk, sys_rst, en_pin, ready, rd_valid_r, cmd_err_r, run_en_r, user_saved_r;
  logic wr_req, snd_req, rd_req;
  logic [4:0] fault_evt, fault_flags_r;
  logic [7:0] cmd_code;
  logic [15:0] wr_data, rd_data_r, vout_target_r, slew_rate_r, fsw_r, phase_r;
  logic [7:0] rc[$];
  logic [15:0] rv[$];
  int errors, compares;
  pmbcfg_bank u_dut (.mclk(mclk), .sys_rst(sys_rst), .vout_strap(V), .fsw_strap(F), .bus_addr(A),
    .en_pin(en_pin), .cmd_code(cmd_code), .wr_req(wr_req), .wr_data(wr_data), .snd_req(snd_req),
    .rd_req(rd_req), .fault_evt(fault_evt), .ready(ready), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
    .cmd_err_r(cmd_err_r), .fault_flags_r(fault_flags_r), .run_en_r(run_en_r),
    .vout_target_r(vout_target_r), .slew_rate_r(slew_rate_r), .fsw_r(fsw_r), .phase_r(phase_r),
    .user_saved_r(user_saved_r));
  pmbcfg_host u_host (.mclk(mclk), .ready(ready), .cmd_code(cmd_code), .wr_req(wr_req),
    .wr_data(wr_data), .snd_req(snd_req), .rd_req(rd_req));
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chkw(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: word %h, want %h", $time, got, exp);
    end
  endtask : chkw
  task automatic chkb(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: bit %b, want %b", $time, got, exp);
    end
  endtask : chkb
  task automatic add(input logic [7:0] c, input logic [15:0] v);
    rc.push_back(c);
    rv.push_back(v);
  endtask : add
  task automatic wr_settle(input logic [7:0] c, input logic [15:0] d);
    u_host.xfer(2'h1, c, d);
    @(negedge mclk);
  endtask : wr_settle
  task automatic pulse(input logic [4:0] f);
    @(negedge mclk);
    fault_evt = f;
    @(negedge mclk);
    fault_evt = 5'h00;
    @(negedge mclk);
  endtask : pulse
  task automatic wait_ready;
    for (int i = 0; i < 16 && ready !== 1'b1; i++) @(negedge mclk);
    chkb(ready, 1'b1);
  endtask : wait_ready
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    errors = 0;
    compares = 0;
    sys_rst = 1'b1;
    en_pin = 1'b0;
    fault_evt = 5'h00;
    add(8'h01, 16'h0000);
    add(8'h02, 16'h0017);
    add(8'h20, 16'h0013);
    add(8'h21, V);
    add(8'h23, 16'h0000);
    add(8'h24, V + VT);
    add(8'h25, V + VW);
    add(8'h26, V - VW);
    add(8'h27, 16'hBA00);
    add(8'h28, 16'h0000);
    add(8'h33, F);
    add(8'h37, {12'h000, A[3:0]});
    add(8'h38, 16'hB2AE);
    add(8'h40, V + VT + VW);
    add(8'h41, 16'h0080);
    add(8'h44, V - VT - VW);
    add(8'h45, 16'h0080);
    add(8'h46, 16'hE280);
    add(8'h4B, 16'hE57F);
    add(8'h4F, 16'hEBE8);
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    wait_ready;
    foreach (rc[i]) begin
      u_host.xfer(2'h3, rc[i], 16'h0000);
      chkw(rd_data_r, rv[i]);
      chkb(rd_valid_r, 1'b1);
    end
    chkw(fsw_r, F);
    chkw(phase_r, {12'h000, A[3:0]});
    u_host.xfer(2'h1, 8'h20, 16'h00FF);
    chkb(cmd_err_r, 1'b1);
    u_host.xfer(2'h3, 8'h03, 16'h0000);
    chkb(cmd_err_r, 1'b1);
    wr_settle(8'h21, 16'h2400);
    chkw(vout_target_r, V + VT);
    wr_settle(8'h23, 16'hFF00);
    chkw(vout_target_r, 16'h2300);
    wr_settle(8'h01, 16'h0020);
    chkw(vout_target_r, V + VW - 16'h0100);
    wr_settle(8'h01, 16'h0010);
    chkw(vout_target_r, V - VW - 16'h0100);
    wr_settle(8'h01, 16'h0030);
    chkw(vout_target_r, V + VW - 16'h0100);
    wr_settle(8'h27, 16'hC200);
    chkw(slew_rate_r, 16'hC200);
    // Pin passes a synchroniser, so allow it several cycles
    en_pin = 1'b1;
    repeat (8) @(negedge mclk);
    chkb(run_en_r, 1'b1);
    en_pin = 1'b0;
    repeat (8) @(negedge mclk);
    chkb(run_en_r, 1'b0);
    wr_settle(8'h02, 16'h0000);
    chkb(run_en_r, 1'b1);
    pulse(5'h1F);
    chkw({11'h000, fault_flags_r}, 16'h001F);
    chkb(run_en_r, 1'b0);
    fork
      u_host.xfer(2'h2, 8'h03, 16'h0000);
      pulse(5'h04);
    join
    chkw({11'h000, fault_flags_r}, 16'h0004);
    chkb(run_en_r, 1'b1);
    wr_settle(8'h45, 16'h0000);
    pulse(5'h02);
    chkb(run_en_r, 1'b1);
    wr_settle(8'h28, 16'h1234);
    u_host.xfer(2'h2, 8'h15, 16'h0000);
    chkb(user_saved_r, 1'b1);
    wr_settle(8'h28, 16'h5678);
    u_host.xfer(2'h2, 8'h16, 16'h0000);
    u_host.xfer(2'h3, 8'h28, 16'h0000);
    chkw(rd_data_r, 16'h1234);
    sys_rst = 1'b1;
    repeat (2) @(negedge mclk);
    chkb(ready, 1'b0);
    chkb(user_saved_r, 1'b0);
    chkw({11'h000, fault_flags_r}, 16'h0000);
    sys_rst = 1'b0;
    wait_ready;
    u_host.xfer(2'h3, 8'h28, 16'h0000);
    chkw(rd_data_r, 16'h0000);
    tally_and_finish;
  end
  initial begin
    #20000;
    errors++;
    tally_and_finish;
  end
endmodule : pmbcfg_bank_tb
bind pmbcfg_bank pmbcfg_properties u_props (.mclk(mclk), .sys_rst(sys_rst), .ready(ready),
  .cmd_code(cmd_code), .wr_req(wr_req), .snd_req(snd_req), .rd_req(rd_req), .fault_evt(fault_evt),
  .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .cmd_err_r(cmd_err_r),
  .fault_flags_r(fault_flags_r), .user_saved_r(user_saved_r));
`default_nettype wire
